/* rtl/eblu_pkg.sv */
// eblu_pkg: shared opcodes, flag positions and constants of the arithmetic unit
package eblu_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned IO_AW   = 6;
  localparam int unsigned BIT_SEL = 3;

  // ==========================================================================
  // status flag bit positions inside the status byte
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_W = 6;

  // ==========================================================================
  // constants used by the datapath
  localparam logic [7:0]  ALL_ONES      = 8'hFF;
  localparam logic [7:0]  ALL_ZERO      = 8'h00;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [5:0]  IO_BIT_LAST   = 6'h1F;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam int unsigned WORD_CYCLES   = 2;

  // ==========================================================================
  // operation select presented by the decoder
  typedef enum logic [4:0] {
    EBLU_OP_NONE,
    EBLU_OP_ADD,
    EBLU_OP_ADD_CARRY,
    EBLU_OP_SUB,
    EBLU_OP_SUBTRACT_WITH_CARRY,
    EBLU_OP_AND,
    EBLU_OP_OR,
    EBLU_OP_EXCLUSIVE_OR,
    EBLU_OP_ONES_COMPLEMENT,
    EBLU_OP_TWOS_COMPLEMENT,
    EBLU_OP_WORD_ADD_IMMEDIATE,
    EBLU_OP_WORD_SUBTRACT_IMMEDIATE,
    EBLU_OP_IO_BIT_SET,
    EBLU_OP_IO_BIT_CLEAR,
    EBLU_OP_SKIP_IF_IO_BIT_ONE,
    EBLU_OP_SKIP_IF_IO_BIT_ZERO,
    EBLU_OP_IO_WRITE
  } eblu_op_t;

endpackage

/* rtl/eblu_adder.sv */
// eblu_adder: 8-bit add/subtract slice with carry, half-carry and overflow
`timescale 1ns/100ps
`default_nettype none

module eblu_adder #(
  parameter int unsigned W = 8
) (
  // operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  input  wire logic         sub,
  // results
  output logic      [W-1:0] sum,
  output logic              cout,
  output logic              half,
  output logic              ovf
);

  // ==========================================================================
  // subtract is a plus not-b plus not-borrow; borrow flags are inverted carries
  logic [W:0]   full;  // full width sum
  logic [4:0]   low;   // low nibble sum
  logic [W-1:0] bx;    // conditioned operand

  always_comb begin
    bx   = sub ? ~b : b;
    full = {1'b0, a} + {1'b0, bx} + {{W{1'b0}}, cin ^ sub};
    low  = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin ^ sub};
    sum  = full[W-1:0];
    cout = full[W] ^ sub;
    half = low[4] ^ sub;
    ovf  = (a[W-1] == bx[W-1]) && (sum[W-1] != a[W-1]);
  end

endmodule

`default_nettype wire

/* rtl/eblu_core.sv */
// eblu_core: 8-bit arithmetic and logic datapath with status flags and io bits
`timescale 1ns/100ps
`default_nettype none

module eblu_core #(
  parameter logic [7:0] W1C_MASK = 8'h00  // io bits that clear on write one
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // operation request from the decoder
  input  wire logic        op_valid,
  input  wire logic [4:0]  op_sel,
  input  wire logic [7:0]  dest_val,
  input  wire logic [7:0]  source_reg,
  input  wire logic [7:0]  dest_hi_val,
  input  wire logic        use_imm,
  input  wire logic [7:0]  imm_val,
  // io access
  input  wire logic [5:0]  io_addr,
  input  wire logic [2:0]  io_bit,
  input  wire logic [7:0]  io_rd_val,
  input  wire logic [7:0]  io_hw_set,
  // results
  output logic             busy,
  output logic             res_valid,
  output logic [7:0]       res_lo,
  output logic [7:0]       res_hi,
  output logic             res_hi_we,
  output logic [7:0]       status,
  output logic             io_we,
  output logic [7:0]       io_wr_val,
  output logic             skip,
  output logic             io_reject,
  output logic [7:0]       io_flags
);

  // ==========================================================================
  // reset release through two flops
  logic rst_m_q;
  logic rst_s_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // ==========================================================================
  // shared adder
  eblu_pkg::eblu_op_t op;
  logic [7:0] opnd_b;   // register or immediate
  logic [7:0] add_a;    // adder left operand
  logic [7:0] add_b;    // adder right operand
  logic       add_cin;  // carry / borrow in
  logic       add_sub;  // subtract select
  logic [7:0] add_sum;
  logic       add_co;
  logic       add_h;
  logic       add_v;

  assign op     = eblu_pkg::eblu_op_t'(op_sel);
  assign opnd_b = use_imm ? imm_val : source_reg;

  eblu_adder #(.W(eblu_pkg::DATA_W)) u_adder (
    .a    (add_a),
    .b    (add_b),
    .cin  (add_cin),
    .sub  (add_sub),
    .sum  (add_sum),
    .cout (add_co),
    .half (add_h),
    .ovf  (add_v)
  );

  // ==========================================================================
  // word operation sequencing
  typedef enum logic {EBLU_ST_IDLE, EBLU_ST_HIGH} eblu_state_t;
  eblu_state_t st_q;
  eblu_state_t st_d;
  logic        wsub_q;   // word op is subtract
  logic        wsub_d;
  logic        wc_q;     // carry between halves
  logic        wc_d;
  logic [7:0]  whi_q;    // high byte source
  logic [7:0]  whi_d;
  logic [7:0]  wlo_q;    // low byte result
  logic [7:0]  wlo_d;

  // ==========================================================================
  // result and flag state
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] res_lo_q;
  logic [7:0] res_lo_d;
  logic [7:0] res_hi_q;
  logic [7:0] res_hi_d;
  logic       valid_q;
  logic       valid_d;
  logic       hi_we_q;
  logic       hi_we_d;
  logic       io_we_q;
  logic       io_we_d;
  logic [7:0] io_wv_q;
  logic [7:0] io_wv_d;
  logic       skip_q;
  logic       skip_d;
  logic       rej_q;
  logic       rej_d;
  logic [7:0] ioflg_q;
  logic [7:0] ioflg_d;

  // ==========================================================================
  // next state of datapath
  always_comb begin
    logic [7:0]  lg;     // logic result
    logic [15:0] wres;   // whole word result
    logic        io_ok;  // address in bit access range
    logic        cin;    // current carry
    lg       = eblu_pkg::ALL_ZERO;
    wres     = eblu_pkg::WORD_ZERO;
    io_ok    = (io_addr <= eblu_pkg::IO_BIT_LAST);
    cin      = status_q[eblu_pkg::FLAG_C];
    add_a    = dest_val;
    add_b    = opnd_b;
    add_cin  = 1'b0;
    add_sub  = 1'b0;
    st_d     = st_q;
    wsub_d   = wsub_q;
    wc_d     = wc_q;
    whi_d    = whi_q;
    wlo_d    = wlo_q;
    status_d = status_q;  // untouched flags hold
    res_lo_d = res_lo_q;
    res_hi_d = res_hi_q;
    valid_d  = 1'b0;
    hi_we_d  = 1'b0;
    io_we_d  = 1'b0;
    io_wv_d  = io_wv_q;
    skip_d   = 1'b0;
    rej_d    = 1'b0;
    // hardware sets io flags; sets win over clears below
    ioflg_d  = ioflg_q;
    case (st_q)
      EBLU_ST_HIGH: begin
        // second cycle: high byte with carry from low
        add_a    = whi_q;
        add_b    = eblu_pkg::ALL_ZERO;
        add_cin  = wc_q;
        add_sub  = wsub_q;
        wres     = {add_sum, wlo_q};
        res_lo_d = wlo_q;
        res_hi_d = add_sum;
        valid_d  = 1'b1;
        hi_we_d  = 1'b1;
        status_d[eblu_pkg::FLAG_Z] = (wres == eblu_pkg::WORD_ZERO);
        status_d[eblu_pkg::FLAG_C] = add_co;
        status_d[eblu_pkg::FLAG_N] = add_sum[7];
        status_d[eblu_pkg::FLAG_V] = wsub_q ? (whi_q[7] & ~add_sum[7])
                                            : (~whi_q[7] & add_sum[7]);
        status_d[eblu_pkg::FLAG_S] = add_sum[7] ^
          (wsub_q ? (whi_q[7] & ~add_sum[7]) : (~whi_q[7] & add_sum[7]));
        st_d     = EBLU_ST_IDLE;
      end
      EBLU_ST_IDLE: begin
        if (op_valid) begin
          valid_d = 1'b1;
          case (op)
            eblu_pkg::EBLU_OP_ADD,
            eblu_pkg::EBLU_OP_ADD_CARRY,
            eblu_pkg::EBLU_OP_SUB,
            eblu_pkg::EBLU_OP_SUBTRACT_WITH_CARRY: begin
              // byte add/sub in one cycle
              add_sub = (op == eblu_pkg::EBLU_OP_SUB) ||
                        (op == eblu_pkg::EBLU_OP_SUBTRACT_WITH_CARRY);
              add_cin = ((op == eblu_pkg::EBLU_OP_ADD_CARRY) ||
                         (op == eblu_pkg::EBLU_OP_SUBTRACT_WITH_CARRY)) & cin;
              res_lo_d = add_sum;
              status_d[eblu_pkg::FLAG_Z] = (add_sum == eblu_pkg::ALL_ZERO);
              status_d[eblu_pkg::FLAG_C] = add_co;
              status_d[eblu_pkg::FLAG_N] = add_sum[7];
              status_d[eblu_pkg::FLAG_V] = add_v;
              status_d[eblu_pkg::FLAG_H] = add_h;
            end
            eblu_pkg::EBLU_OP_AND,
            eblu_pkg::EBLU_OP_OR,
            eblu_pkg::EBLU_OP_EXCLUSIVE_OR: begin
              // logic ops touch only Z N V
              if (op == eblu_pkg::EBLU_OP_AND) begin
                lg = dest_val & opnd_b;
              end else if (op == eblu_pkg::EBLU_OP_OR) begin
                lg = dest_val | opnd_b;
              end else begin
                lg = dest_val ^ source_reg;
              end
              res_lo_d = lg;
              status_d[eblu_pkg::FLAG_Z] = (lg == eblu_pkg::ALL_ZERO);
              status_d[eblu_pkg::FLAG_N] = lg[7];
              status_d[eblu_pkg::FLAG_V] = 1'b0;
            end
            eblu_pkg::EBLU_OP_ONES_COMPLEMENT,
            eblu_pkg::EBLU_OP_TWOS_COMPLEMENT: begin
              // 0xFF - d or 0x00 - d
              add_a   = (op == eblu_pkg::EBLU_OP_ONES_COMPLEMENT) ?
                        eblu_pkg::ALL_ONES : eblu_pkg::ALL_ZERO;
              add_b   = dest_val;
              add_sub = 1'b1;
              res_lo_d = add_sum;
              status_d[eblu_pkg::FLAG_Z] = (add_sum == eblu_pkg::ALL_ZERO);
              status_d[eblu_pkg::FLAG_N] = add_sum[7];
              status_d[eblu_pkg::FLAG_V] = add_v;
              if (op == eblu_pkg::EBLU_OP_ONES_COMPLEMENT) begin
                status_d[eblu_pkg::FLAG_C] = 1'b1;
              end else begin
                status_d[eblu_pkg::FLAG_C] = (add_sum != eblu_pkg::ALL_ZERO);
                status_d[eblu_pkg::FLAG_H] = add_h;
              end
            end
            eblu_pkg::EBLU_OP_WORD_ADD_IMMEDIATE,
            eblu_pkg::EBLU_OP_WORD_SUBTRACT_IMMEDIATE: begin
              // low byte now, high byte next cycle
              add_b   = imm_val;
              add_sub = (op == eblu_pkg::EBLU_OP_WORD_SUBTRACT_IMMEDIATE);
              wsub_d  = add_sub;
              wc_d    = add_co;
              whi_d   = dest_hi_val;
              wlo_d   = add_sum;
              valid_d = 1'b0;
              st_d    = EBLU_ST_HIGH;
            end
            eblu_pkg::EBLU_OP_IO_BIT_SET,
            eblu_pkg::EBLU_OP_IO_BIT_CLEAR: begin
              if (!io_ok) begin
                rej_d = 1'b1;  // out of bit range
              end else begin
                // only the addressed bit written; w1c others masked
                io_we_d = 1'b1;
                io_wv_d = (io_rd_val & ~W1C_MASK);
                io_wv_d[io_bit] = (op == eblu_pkg::EBLU_OP_IO_BIT_SET);
                if ((op == eblu_pkg::EBLU_OP_IO_BIT_SET) &&
                    W1C_MASK[io_bit]) begin
                  ioflg_d[io_bit] = 1'b0;  // write one clears
                end
              end
            end
            eblu_pkg::EBLU_OP_SKIP_IF_IO_BIT_ONE,
            eblu_pkg::EBLU_OP_SKIP_IF_IO_BIT_ZERO: begin
              if (!io_ok) begin
                rej_d = 1'b1;
              end else begin
                skip_d = io_rd_val[io_bit] ==
                         (op == eblu_pkg::EBLU_OP_SKIP_IF_IO_BIT_ONE);
              end
            end
            eblu_pkg::EBLU_OP_IO_WRITE: begin
              // full write: ones clear w1c flags
              io_we_d = 1'b1;
              io_wv_d = opnd_b;
              ioflg_d = ioflg_q & ~(opnd_b & W1C_MASK);
            end
            default: begin
              valid_d = 1'b0;
            end
          endcase
        end
      end
      default: begin
        st_d = EBLU_ST_IDLE;
      end
    endcase
    ioflg_d = ioflg_d | (io_hw_set & W1C_MASK);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      st_q     <= EBLU_ST_IDLE;
      wsub_q   <= 1'b0;
      wc_q     <= 1'b0;
      whi_q    <= eblu_pkg::ALL_ZERO;
      wlo_q    <= eblu_pkg::ALL_ZERO;
      status_q <= eblu_pkg::STATUS_RESET;
      res_lo_q <= eblu_pkg::ALL_ZERO;
      res_hi_q <= eblu_pkg::ALL_ZERO;
      valid_q  <= 1'b0;
      hi_we_q  <= 1'b0;
      io_we_q  <= 1'b0;
      io_wv_q  <= eblu_pkg::ALL_ZERO;
      skip_q   <= 1'b0;
      rej_q    <= 1'b0;
      ioflg_q  <= eblu_pkg::ALL_ZERO;
    end else begin
      st_q     <= st_d;
      wsub_q   <= wsub_d;
      wc_q     <= wc_d;
      whi_q    <= whi_d;
      wlo_q    <= wlo_d;
      status_q <= status_d;
      res_lo_q <= res_lo_d;
      res_hi_q <= res_hi_d;
      valid_q  <= valid_d;
      hi_we_q  <= hi_we_d;
      io_we_q  <= io_we_d;
      io_wv_q  <= io_wv_d;
      skip_q   <= skip_d;
      rej_q    <= rej_d;
      ioflg_q  <= ioflg_d;
    end
  end

  // ==========================================================================
  // outputs straight from flops
  assign busy      = (st_q == EBLU_ST_HIGH);
  assign res_valid = valid_q;
  assign res_lo    = res_lo_q;
  assign res_hi    = res_hi_q;
  assign res_hi_we = hi_we_q;
  assign status    = status_q;
  assign io_we     = io_we_q;
  assign io_wr_val = io_wv_q;
  assign skip      = skip_q;
  assign io_reject = rej_q;
  assign io_flags  = ioflg_q;

endmodule

`default_nettype wire

/* dv/eblu_core_sva.sv */
// checker: port-level assertions for the arithmetic unit
`timescale 1ns/100ps
`default_nettype none

module eblu_core_sva #(
  parameter logic [7:0] W1C_MASK = 8'h00
) (
  // clock, reset and request
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       op_valid,
  input wire logic [4:0] op_sel,
  input wire logic [7:0] dest_val,
  input wire logic [7:0] source_reg,
  input wire logic       use_imm,
  input wire logic [7:0] imm_val,
  input wire logic [5:0] io_addr,
  input wire logic [2:0] io_bit,
  input wire logic [7:0] io_rd_val,
  // results
  input wire logic       busy,
  input wire logic       res_valid,
  input wire logic [7:0] res_lo,
  input wire logic       res_hi_we,
  input wire logic [7:0] status,
  input wire logic       io_we,
  input wire logic [7:0] io_wr_val,
  input wire logic       io_reject
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // a request of one kind taken at this edge
  sequence s_take(logic [4:0] o);
    op_valid && !busy && op_sel == o;
  endsequence
  // second cycle of a word op, then the result
  sequence s_word_done;
    busy ##1 (res_valid && res_hi_we && !busy);
  endsequence
  logic logic_op;
  assign logic_op = op_valid && !busy && op_sel inside {
    eblu_pkg::EBLU_OP_AND, eblu_pkg::EBLU_OP_OR,
    eblu_pkg::EBLU_OP_EXCLUSIVE_OR};

  add_sum_a: assert property (s_take(eblu_pkg::EBLU_OP_ADD) ##0 !use_imm
    |=> res_valid && res_lo == $past(dest_val) + $past(source_reg))
    else $error("add result wrong");
  word_two_a: assert property (op_valid && !busy &&
    op_sel inside {eblu_pkg::EBLU_OP_WORD_ADD_IMMEDIATE,
    eblu_pkg::EBLU_OP_WORD_SUBTRACT_IMMEDIATE} |=> s_word_done)
    else $error("word op timing wrong");
  sub_borrow_a: assert property (s_take(eblu_pkg::EBLU_OP_SUB)
    |=> status[eblu_pkg::FLAG_C] == (($past(use_imm) ? $past(imm_val)
    : $past(source_reg)) > $past(dest_val))) else $error("borrow wrong");
  logic_keep_a: assert property (logic_op |=>
    $stable(status[eblu_pkg::FLAG_C]) && $stable(status[eblu_pkg::FLAG_H])
    && !status[eblu_pkg::FLAG_V]) else $error("logic flags wrong");
  logic_zn_a: assert property (logic_op |=>
    status[eblu_pkg::FLAG_Z] == (res_lo == 8'h00) &&
    status[eblu_pkg::FLAG_N] == res_lo[7]) else $error("logic z n wrong");
  com_res_a: assert property (s_take(eblu_pkg::EBLU_OP_ONES_COMPLEMENT)
    |=> res_lo == ~$past(dest_val) && status[eblu_pkg::FLAG_C])
    else $error("complement wrong");
  io_range_a: assert property (op_valid && !busy && io_addr > 6'h1F &&
    op_sel inside {eblu_pkg::EBLU_OP_IO_BIT_SET,
    eblu_pkg::EBLU_OP_IO_BIT_CLEAR}
    |=> io_reject && !io_we) else $error("io range not refused");
  io_single_a: assert property (s_take(eblu_pkg::EBLU_OP_IO_BIT_SET)
    ##0 io_addr <= 6'h1F |=> io_we && io_wr_val == (($past(io_rd_val)
    & ~W1C_MASK) | (8'h01 << $past(io_bit)))) else $error("io set wrong");
endmodule

bind eblu_core eblu_core_sva #(.W1C_MASK(W1C_MASK)) i_eblu_core_sva (
  .core_clk, .rst_b, .op_valid, .op_sel, .dest_val, .source_reg,
  .use_imm, .imm_val, .io_addr, .io_bit, .io_rd_val, .busy, .res_valid,
  .res_lo, .res_hi_we, .status, .io_we, .io_wr_val, .io_reject);
`default_nettype wire

/* dv/eblu_io_model.sv */
// io register file model facing the unit's io port
`timescale 1ns/100ps
`default_nettype none

module eblu_io_model #(
  parameter logic [7:0] W1C_MASK = 8'h00  // flags cleared by writing one
) (
  input  wire logic       core_clk,
  input  wire logic       hw_evt,  // raise every flag bit this cycle
  input  wire logic [5:0] io_addr,
  input  wire logic       io_we,
  input  wire logic [7:0] io_wr_val,
  output logic      [7:0] io_rd_val,
  output logic      [7:0] io_hw_set
);
  logic [7:0] mem_q [64];  // io space, all start at 8'h81
  initial for (int i = 0; i < 64; i++) mem_q[i] = 8'h81;
  assign io_rd_val = mem_q[io_addr];
  assign io_hw_set = hw_evt ? W1C_MASK : 8'h00;  // hardware flag events
  // write: plain bits take value, flag bits clear on one
  always @(posedge core_clk) begin
    if (io_we) mem_q[io_addr] <= (io_wr_val & ~W1C_MASK) |
      (mem_q[io_addr] & W1C_MASK & ~io_wr_val);
  end
endmodule
`default_nettype wire

/* dv/eight_bit_arith_logic_unit_bench.sv */
// testbench: scenarios for the arithmetic unit
`timescale 1ns/100ps
`default_nettype none

module eight_bit_arith_logic_unit_bench;
  logic core_clk = 0, rst_b = 0, op_valid = 0, use_imm = 0, hw_evt = 0;
  logic [4:0] op_sel = 0;
  logic [7:0] dest_val = 0, source_reg = 0, dest_hi_val = 0, imm_val = 0;
  logic [5:0] io_addr = 0;
  logic [2:0] io_bit = 0;
  logic [7:0] io_rd_val, io_hw_set, res_lo, res_hi, status, io_wr_val;
  logic [7:0] io_flags;
  logic busy, res_valid, res_hi_we, io_we, skip, io_reject;
  int n_mismatch = 0, checks_done = 0;

  eblu_core #(.W1C_MASK(8'h80)) i_eblu_core (.core_clk, .rst_b,
    .op_valid, .op_sel, .dest_val, .source_reg, .dest_hi_val, .use_imm,
    .imm_val, .io_addr, .io_bit, .io_rd_val, .io_hw_set, .busy, .res_valid,
    .res_lo, .res_hi, .res_hi_we, .status, .io_we, .io_wr_val, .skip,
    .io_reject, .io_flags);
  eblu_io_model #(.W1C_MASK(8'h80)) i_eblu_io_model (.core_clk, .hw_evt,
    .io_addr,
    .io_we, .io_wr_val, .io_rd_val, .io_hw_set);

  initial forever #4 core_clk = ~core_clk;

  task automatic chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one request, taken at the next edge, then settle
  task automatic go(input logic [4:0] o, input logic [7:0] d, s, k,
                    input logic ui);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_sel <= o;
    dest_val <= d;
    source_reg <= s;
    imm_val <= k;
    use_imm <= ui;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic io(input logic [4:0] o, input logic [5:0] a,
                    input logic [2:0] b);
    @(posedge core_clk);
    io_addr <= a;
    io_bit <= b;
    go(o, 8'h00, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic word(input logic [4:0] o, input logic [7:0] h, l, k,
                      input logic [7:0] eh, el, ef);
    @(posedge core_clk);
    dest_hi_val <= h;
    go(o, l, 8'h00, k, 1'b1);
    chk("busy", busy, 1'b1);
    @(posedge core_clk);
    #1;
    chk("wvalid", {busy, res_valid, res_hi_we}, 3'b011);
    chk("word", {res_hi, res_lo}, {eh, el});
    chk("wflags", status & 8'h1F, ef);
  endtask

  task automatic t_add;
    go(eblu_pkg::EBLU_OP_ADD, 8'hFF, 8'h01, 8'h00, 1'b0);
    chk("add", {res_valid, res_lo}, 9'h100);
    chk("aflags", status & 8'h2F, 8'h23);
    go(eblu_pkg::EBLU_OP_ADD_CARRY, 8'h10, 8'h20, 8'h00, 1'b0);
    chk("adc", res_lo, 8'h31);
  endtask
  task automatic t_sub;
    go(eblu_pkg::EBLU_OP_SUB, 8'h10, 8'h00, 8'h20, 1'b1);
    chk("subtract_immediate", {res_lo, status & 8'h2F}, 16'hF005);
    go(eblu_pkg::EBLU_OP_SUBTRACT_WITH_CARRY, 8'h05, 8'h01, 8'h00, 1'b0);
    chk("sbc", {res_lo, status & 8'h2F}, 16'h0300);
    go(eblu_pkg::EBLU_OP_SUB, 8'h00, 8'h01, 8'h00, 1'b0);
    chk("sub", {res_lo, status & 8'h2F}, 16'hFF25);
    go(eblu_pkg::EBLU_OP_SUBTRACT_WITH_CARRY, 8'h05, 8'h00, 8'h01, 1'b1);
    chk("subtract_carry_immediate", res_lo, 8'h03);
  endtask
  task automatic t_word;
    word(eblu_pkg::EBLU_OP_WORD_ADD_IMMEDIATE, 8'h00, 8'hFF, 8'h01,
         8'h01, 8'h00, 8'h00);
    word(eblu_pkg::EBLU_OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'h01,
         8'hFF, 8'hFF, 8'h15);
  endtask
  task automatic t_logic;
    go(eblu_pkg::EBLU_OP_AND, 8'hF0, 8'h0F, 8'h00, 1'b0);
    chk("and", {res_lo, status & 8'h2F}, 16'h0003);
    go(eblu_pkg::EBLU_OP_OR, 8'h80, 8'h00, 8'h01, 1'b1);
    chk("ori", {res_lo, status & 8'h2F}, 16'h8105);
    go(eblu_pkg::EBLU_OP_EXCLUSIVE_OR, 8'hFF, 8'hFF, 8'h00, 1'b0);
    chk("xor", {res_lo, status & 8'h2F}, 16'h0003);
  endtask
  task automatic t_comp;
    go(eblu_pkg::EBLU_OP_ONES_COMPLEMENT, 8'h55, 8'h00, 8'h00, 1'b0);
    chk("com", {res_lo, status & 8'h0F}, 16'hAA05);
    go(eblu_pkg::EBLU_OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 8'h00, 1'b0);
    chk("neg", {res_lo, status & 8'h2F}, 16'hFF25);
  endtask
  task automatic t_io;
    io(eblu_pkg::EBLU_OP_IO_BIT_SET, 6'h1F, 3'd3);
    chk("set", {io_we, io_wr_val}, 9'h109);
    io(eblu_pkg::EBLU_OP_SKIP_IF_IO_BIT_ONE, 6'h1F, 3'd3);
    chk("skip1", skip, 1'b1);
    io(eblu_pkg::EBLU_OP_SKIP_IF_IO_BIT_ZERO, 6'h1F, 3'd3);
    chk("skip0", skip, 1'b0);
    io(eblu_pkg::EBLU_OP_IO_BIT_CLEAR, 6'h1F, 3'd0);
    chk("clr", {io_we, io_wr_val}, 9'h108);
    io(eblu_pkg::EBLU_OP_IO_BIT_SET, 6'h20, 3'd1);
    chk("range", {io_reject, io_we}, 2'b10);
  endtask
  // write-one-clear flags: hardware set, full write, set wins, bit set
  task automatic t_flag;
    @(posedge core_clk);
    hw_evt <= 1'b1;
    @(posedge core_clk);
    hw_evt <= 1'b0;
    #1;
    chk("hwset", io_flags, 8'h80);
    go(eblu_pkg::EBLU_OP_IO_WRITE, 8'h00, 8'h00, 8'h80, 1'b1);
    chk("iowr", {io_we, io_wr_val, io_flags}, 17'h18000);
    @(posedge core_clk);
    hw_evt <= 1'b1;
    go(eblu_pkg::EBLU_OP_IO_WRITE, 8'h00, 8'h00, 8'h80, 1'b1);
    hw_evt <= 1'b0;
    chk("setwin", io_flags, 8'h80);
    io(eblu_pkg::EBLU_OP_IO_BIT_SET, 6'h1F, 3'd7);
    chk("w1cset", {io_we, io_wr_val, io_flags}, 17'h18800);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("reset", {busy, res_valid, status}, 10'h000);
    t_add();
    t_sub();
    t_word();
    t_logic();
    t_comp();
    t_io();
    t_flag();
    close_out();
  end
  // watchdog
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
